// ---- core/rsofs_cluster_guard.sv ----
`timescale 1ns/1ns
module rsofs_cluster_guard
	import rsofs_pkg::*;
#(
	parameter int unsigned REARM_CYC = REARM_CYCLES
) (
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rstn_i,
	// Cluster control and status
	rsofs_cluster_if.guard  cl
);

	localparam logic [REARM_CNT_W-1:0] REARM_LAST =
		REARM_CNT_W'(REARM_CYC - 1);
	localparam logic [PROBE_CNT_W-1:0] PROBE_LAST =
		PROBE_CNT_W'(PROBE_CYCLES - 1);

	logic [REARM_CNT_W-1:0] rearm_cnt;
	logic [PROBE_CNT_W-1:0] probe_cnt;
	logic                   probing;
	logic                   rearm_now;
	logic                   trip;

	assign rearm_now = cl.blank && !cl.inhibit && (rearm_cnt == REARM_LAST);
	// Sensing lags the pins, so a fresh retry ignores stale fault samples
	assign trip = cl.fault && !probing;

	// Time spent blanked; frozen at zero while re-arming is inhibited
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			rearm_cnt <= '0;
		else if (!cl.blank || cl.inhibit || rearm_now)
			rearm_cnt <= '0;
		else
			rearm_cnt <= rearm_cnt + 1'b1;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			probing   <= 1'b0;
			probe_cnt <= '0;
		end else if (rearm_now) begin
			probing   <= 1'b1;
			probe_cnt <= '0;
		end else if (probing) begin
			probing   <= (probe_cnt != PROBE_LAST);
			probe_cnt <= probe_cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			cl.blank <= 1'b0;
		else if (trip)
			cl.blank <= 1'b1;
		else if (rearm_now)
			cl.blank <= 1'b0;
		else if (cl.clear)
			cl.blank <= 1'b0;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			cl.flag <= 1'b0;
		else if (trip)
			cl.flag <= 1'b1;
		else if (cl.clear)
			cl.flag <= 1'b0;
	end

endmodule : rsofs_cluster_guard

// ---- core/rsofs_cluster_if.sv ----
`timescale 1ns/1ns
interface rsofs_cluster_if;
	logic fault;
	logic inhibit;
	logic clear;
	logic blank;
	logic flag;

	modport guard (
		input  fault,
		input  inhibit,
		input  clear,
		output blank,
		output flag
	);

	modport sup (
		output fault,
		output inhibit,
		output clear,
		input  blank,
		input  flag
	);
endinterface : rsofs_cluster_if

// ---- core/rsofs_pkg.sv ----
package rsofs_pkg;

	// Channel and cluster geometry
	localparam int N_CH      = 16;
	localparam int CL_SIZE   = 4;
	localparam int N_CL      = (N_CH + CL_SIZE - 1) / CL_SIZE;
	localparam int N_DIN     = 16;
	localparam int DIN_SEL_W = 4;

	// Remote run/stop request sources, one bit each
	localparam int N_EXT    = 3;
	localparam int EXT_TOOL = 0;
	localparam int EXT_WORD = 1;
	localparam int EXT_WEB  = 2;

	// Channels below this index sense both rails on transistor outputs
	localparam int BOTH_RAIL_CH = 4;

	// Output stage kinds
	localparam logic [1:0] KIND_SOURCE = 2'h0;
	localparam logic [1:0] KIND_SINK   = 2'h1;
	localparam logic [1:0] KIND_RELAY  = 2'h2;

	// Reset values
	localparam logic [N_CH-1:0] OUT_RST = 16'h0000;
	localparam logic [N_CL-1:0] CL_RST  = 4'h0;

	// Re-arm timing
	localparam int REARM_PERIOD_MS = 1000;
	localparam int MCLK_KHZ        = 10000;
	localparam int REARM_CYCLES    = REARM_PERIOD_MS * MCLK_KHZ;
	localparam int REARM_CNT_W     = 24;
	localparam int PROBE_CYCLES    = 4;
	localparam int PROBE_CNT_W     = 3;

	typedef enum logic [1:0] {
		ST_STOP,
		ST_RUN,
		ST_EXC
	} rsofs_state_t;

	// Which faults a channel may report: bit 1 high rail, bit 0 low rail
	function automatic logic [1:0] rsofs_sense(input logic [1:0] kind,
	                                           input int ch);
		logic [1:0] m;
		m = 2'h0;
		if (kind == KIND_SOURCE)
			m = (ch < BOTH_RAIL_CH) ? 2'h3 : 2'h1;
		else if (kind == KIND_SINK)
			m = (ch < BOTH_RAIL_CH) ? 2'h3 : 2'h2;
		return m;
	endfunction : rsofs_sense

	// Channels belonging to one cluster
	function automatic logic [N_CH-1:0] rsofs_cl_mask(input int k);
		logic [N_CH-1:0] m;
		m = '0;
		for (int c = 0; c < N_CH; c++)
			m[c] = ((c / CL_SIZE) == k);
		return m;
	endfunction : rsofs_cl_mask

endpackage : rsofs_pkg

// ---- core/rsofs_top.sv ----
`timescale 1ns/1ns
module rsofs_top
	import rsofs_pkg::*;
#(
	parameter int unsigned REARM_CYC = REARM_CYCLES
) (
	// Clock and reset
	input  wire logic                 mclk_i,
	input  wire logic                 rstn_i,
	// Run/stop sources
	input  wire logic                 switch_run_i,
	input  wire logic [N_DIN-1:0]     din_i,
	input  wire logic                 runstop_in_en_i,
	input  wire logic [DIN_SEL_W-1:0] runstop_sel_i,
	input  wire logic [N_EXT-1:0]     ext_run_i,
	input  wire logic [N_EXT-1:0]     ext_stop_i,
	input  wire logic                 exception_i,
	// Output channel values
	input  wire logic [N_CH-1:0]      out_cmd_i,
	input  wire logic [N_CH-1:0]      fallback_i,
	input  wire logic [N_CH-1:0]      pulse_train_output_i,
	input  wire logic [1:0]           out_kind_i,
	// Protection sensing and control
	input  wire logic [N_CH-1:0]      short_low_i,
	input  wire logic [N_CH-1:0]      short_high_i,
	input  wire logic                 rearm_inhibit_i,
	input  wire logic                 fault_clear_i,
	// Channel drive
	output logic      [N_CH-1:0]      output_channels_o,
	// Controller state
	output logic                      running_o,
	output logic                      exception_o,
	output logic                      fallback_active_o,
	output logic                      run_entered_o,
	output logic                      stop_entered_o,
	output logic                      ext_refused_o,
	output logic                      hold_switch_o,
	output logic                      hold_input_o,
	// Protection status
	output logic      [N_CH-1:0]      ch_fault_o,
	output logic      [N_CL-1:0]      cluster_blank_o,
	output logic      [N_CL-1:0]      cluster_fault_o
);

	// Pin synchronisers
	logic              sw_s1;
	logic              sw_s2;
	logic [N_DIN-1:0]  din_s1;
	logic [N_DIN-1:0]  din_s2;
	logic [N_CH-1:0]   lo_s1;
	logic [N_CH-1:0]   lo_s2;
	logic [N_CH-1:0]   hi_s1;
	logic [N_CH-1:0]   hi_s2;

	// Edge history
	logic              sw_prev;
	logic              rs_prev;
	logic              rs_lvl;
	logic              sw_rise;
	logic              rs_rise;

	// Run/stop state
	rsofs_state_t      state;
	rsofs_state_t      next_state;
	logic              refused;
	logic              held_sw;
	logic              held_in;
	logic              ext_run;
	logic              ext_stop;

	// Output path
	logic [N_CH-1:0]   ch_fault;
	logic [N_CH-1:0]   ch_blank;
	logic [N_CL-1:0]   cl_blank;
	logic [N_CL-1:0]   cl_flag;
	logic [N_CH-1:0]   fb_value;
	logic [N_CH-1:0]   next_out;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sw_s1  <= 1'b0;
			sw_s2  <= 1'b0;
			din_s1 <= '0;
			din_s2 <= '0;
		end else begin
			sw_s1  <= switch_run_i;
			sw_s2  <= sw_s1;
			din_s1 <= din_i;
			din_s2 <= din_s1;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lo_s1 <= '0;
			lo_s2 <= '0;
			hi_s1 <= '0;
			hi_s2 <= '0;
		end else begin
			lo_s1 <= short_low_i;
			lo_s2 <= lo_s1;
			hi_s1 <= short_high_i;
			hi_s2 <= hi_s1;
		end
	end

	assign rs_lvl = din_s2[runstop_sel_i];

	// History reset to stop: a switch resting at run starts after reset
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sw_prev <= 1'b0;
			rs_prev <= 1'b0;
		end else begin
			sw_prev <= sw_s2;
			rs_prev <= rs_lvl;
		end
	end

	assign sw_rise = sw_s2 && !sw_prev;
	assign rs_rise = rs_lvl && !rs_prev;

	assign ext_run  = |ext_run_i;
	assign ext_stop = |ext_stop_i;

	always_comb begin
		next_state = state;
		refused    = 1'b0;
		held_sw    = 1'b0;
		held_in    = 1'b0;
		case (state)
			ST_EXC: begin
				if (!exception_i)
					next_state = ST_STOP;
			end
			default: begin
				if (exception_i) begin
					next_state = ST_EXC;
				end else if (!sw_s2) begin
					next_state = ST_STOP;
					held_sw    = 1'b1;
					refused    = ext_run || ext_stop;
				end else if (runstop_in_en_i && !rs_lvl) begin
					next_state = ST_STOP;
					held_in    = 1'b1;
					refused    = ext_run || ext_stop;
				end else if (sw_rise) begin
					next_state = ST_RUN;
				end else if (runstop_in_en_i && rs_rise) begin
					next_state = ST_RUN;
				end else if (ext_stop) begin
					next_state = ST_STOP;
				end else if (ext_run) begin
					next_state = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			state <= ST_STOP;
		else
			state <= next_state;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			running_o         <= 1'b0;
			exception_o       <= 1'b0;
			fallback_active_o <= 1'b1;
		end else begin
			running_o         <= (next_state == ST_RUN);
			exception_o       <= (next_state == ST_EXC);
			fallback_active_o <= (next_state != ST_RUN);
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			run_entered_o  <= 1'b0;
			stop_entered_o <= 1'b0;
			ext_refused_o  <= 1'b0;
			hold_switch_o  <= 1'b0;
			hold_input_o   <= 1'b0;
		end else begin
			run_entered_o  <= (next_state == ST_RUN) && (state != ST_RUN);
			stop_entered_o <= (next_state != ST_RUN) && (state == ST_RUN);
			ext_refused_o  <= refused;
			hold_switch_o  <= held_sw;
			hold_input_o   <= held_in;
		end
	end

	// Fault qualification per channel
	genvar c;
	generate
		for (c = 0; c < N_CH; c++) begin : g_ch
			logic [1:0] sense;
			assign sense       = rsofs_sense(out_kind_i, c);
			assign ch_fault[c] = (lo_s2[c] && sense[0])
			                  || (hi_s2[c] && sense[1]);
		end
	endgenerate

	genvar k;
	generate
		for (k = 0; k < N_CL; k++) begin : g_cl
			rsofs_cluster_if cl_if ();

			assign cl_if.fault   = |(ch_fault & rsofs_cl_mask(k));
			assign cl_if.inhibit = rearm_inhibit_i;
			assign cl_if.clear   = fault_clear_i;
			assign cl_blank[k]   = cl_if.blank;
			assign cl_flag[k]    = cl_if.flag;

			rsofs_cluster_guard #(
				.REARM_CYC (REARM_CYC)
			) u_guard (
				.mclk_i (mclk_i),
				.rstn_i (rstn_i),
				.cl     (cl_if.guard)
			);
		end
	endgenerate

	always_comb begin
		ch_blank = '0;
		for (int j = 0; j < N_CL; j++) begin
			if (cl_blank[j])
				ch_blank = ch_blank | rsofs_cl_mask(j);
		end
	end

	assign fb_value = fallback_i & ~pulse_train_output_i;

	always_comb begin
		if (state == ST_RUN)
			next_out = out_cmd_i;
		else
			next_out = fb_value;
		next_out = next_out & ~ch_blank;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			output_channels_o <= OUT_RST;
		else
			output_channels_o <= next_out;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ch_fault_o      <= OUT_RST;
			cluster_blank_o <= CL_RST;
			cluster_fault_o <= CL_RST;
		end else begin
			ch_fault_o      <= ch_fault;
			cluster_blank_o <= cl_blank;
			cluster_fault_o <= cl_flag;
		end
	end

endmodule : rsofs_top

// ---- sim/rsofs_chk.sv ----
`timescale 1ns/1ns
module rsofs_chk
	import rsofs_pkg::*;
#(
	parameter int unsigned REARM_CYC = REARM_CYCLES
) (
	// Clock, reset and inputs
	input wire logic mclk_i, rstn_i, switch_run_i, exception_i,
	input wire logic rearm_inhibit_i, fault_clear_i,
	input wire logic [N_EXT-1:0] ext_run_i, ext_stop_i,
	input wire logic [N_CH-1:0] out_cmd_i, fallback_i,
	input wire logic [N_CH-1:0] pulse_train_output_i, short_low_i,
	input wire logic [1:0] out_kind_i,
	// Outputs watched
	input wire logic running_o, exception_o, run_entered_o,
	input wire logic stop_entered_o, ext_refused_o,
	input wire logic [N_CH-1:0] output_channels_o, ch_fault_o,
	input wire logic [N_CL-1:0] cluster_blank_o, cluster_fault_o
);
	logic [N_CH-1:0] bmask;
	logic [31:0]     blank_cnt;

	always_comb begin
		for (int c = 0; c < N_CH; c++) begin
			bmask[c] = cluster_blank_o[c / CL_SIZE];
		end
	end

	// Cluster 1 blanked while re-arm allowed
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			blank_cnt <= '0;
		end else if (cluster_blank_o[1] && !rearm_inhibit_i) begin
			blank_cnt <= blank_cnt + 1;
		end else begin
			blank_cnt <= '0;
		end
	end

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	sequence src_lo5;
		(short_low_i[5] && !fault_clear_i && out_kind_i == KIND_SOURCE) [*4];
	endsequence
	sequence src_quiet;
		(out_kind_i == KIND_SOURCE && short_low_i[15:4] == 12'h000) [*5];
	endsequence

	fb_value_a: assert property ($past(rstn_i) |-> output_channels_o ==
		(($past(running_o) ? $past(out_cmd_i) : $past(fallback_i) &
		~$past(pulse_train_output_i)) & ~bmask))
		else $error("channel drive differs from state");
	sw_hold_a: assert property (!$past(switch_run_i, 2) &&
		!$past(switch_run_i, 3) |-> !running_o)
		else $error("running with switch at stop");
	refuse_a: assert property ((|ext_run_i) && !exception_o &&
		!exception_i && !$past(switch_run_i) && !$past(switch_run_i, 2)
		|-> ##[0:1] ext_refused_o)
		else $error("remote request not refused");
	stop_req_a: assert property (running_o && (|ext_stop_i) &&
		!exception_i |=> !running_o && stop_entered_o)
		else $error("remote stop not taken");
	run_pulse_a: assert property (run_entered_o |->
		running_o && !$past(running_o))
		else $error("run entry pulse without entry");
	flt_set_a: assert property (src_lo5 |=> cluster_fault_o[1])
		else $error("fault did not flag cluster");
	src_high_a: assert property (src_quiet |->
		ch_fault_o[15:4] == 12'h000)
		else $error("high rail short reported");
	inhibit_a: assert property (cluster_blank_o[1] &&
		rearm_inhibit_i && $past(rearm_inhibit_i) && !fault_clear_i &&
		!$past(fault_clear_i) |=> cluster_blank_o[1])
		else $error("inhibited cluster re-armed");
	rearm_due_a: assert property (blank_cnt <= REARM_CYC + 3)
		else $error("cluster not re-armed in time");
endmodule : rsofs_chk

bind rsofs_top rsofs_chk #(.REARM_CYC(REARM_CYC)) i_rsofs_chk (.*);

// ---- sim/rsofs_load_model.sv ----
`timescale 1ns/1ns
module rsofs_load_model
	import rsofs_pkg::*;
(
	// Drive from the block
	input  wire logic [N_CH-1:0] drive_i,
	// Shorts placed by the bench
	input  wire logic [N_CH-1:0] to_low_i,
	input  wire logic [N_CH-1:0] to_high_i,
	// Sensed faults back to the block
	output logic      [N_CH-1:0] short_low_o,
	output logic      [N_CH-1:0] short_high_o
);
	// Current into a grounded load flows only while driven high
	assign short_low_o  = to_low_i & drive_i;
	assign short_high_o = to_high_i;
endmodule : rsofs_load_model

// ---- sim/test_rsofs_top.sv ----
`timescale 1ns/1ns
module test_rsofs_top;
	import rsofs_pkg::*;
	localparam int unsigned RC = 50;
	logic mclk_i = 1'b0, rstn_i = 1'b0, switch_run_i = 1'b0;
	logic runstop_in_en_i = 1'b0, exception_i = 1'b0;
	logic rearm_inhibit_i = 1'b0, fault_clear_i = 1'b0;
	logic [N_DIN-1:0] din_i = '0;
	logic [DIN_SEL_W-1:0] runstop_sel_i = 4'h9;
	logic [N_EXT-1:0] ext_run_i = '0, ext_stop_i = '0;
	logic [N_CH-1:0] out_cmd_i = 16'h5a3c, fallback_i = 16'h00ff;
	logic [N_CH-1:0] pulse_train_output_i = 16'h0003;
	logic [N_CH-1:0] lo_m = '0, hi_m = '0, short_low_i, short_high_i;
	logic [N_CH-1:0] output_channels_o, ch_fault_o;
	logic [1:0] out_kind_i = KIND_SOURCE;
	logic running_o, exception_o, fallback_active_o, run_entered_o;
	logic stop_entered_o, ext_refused_o, hold_switch_o, hold_input_o;
	logic [N_CL-1:0] cluster_blank_o, cluster_fault_o;
	int err_count = 0, checks_done = 0, cyc = 0, n;

	rsofs_top #(.REARM_CYC(RC)) i_rsofs_top (.*);
	rsofs_load_model i_rsofs_load_model (.drive_i(output_channels_o),
		.to_low_i(lo_m), .to_high_i(hi_m), .short_low_o(short_low_i),
		.short_high_o(short_high_i));

	always #50 mclk_i = ~mclk_i;

	task automatic step(input int k);
		repeat (k) @(posedge mclk_i);
		#10;
	endtask : step

	task automatic chk(input string nm, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Status nibble: running, run entry, stop entry, refused
	task automatic look(input string nm, input logic [15:0] exp);
		chk(nm, 16'({running_o, run_entered_o, stop_entered_o,
			ext_refused_o}), exp);
	endtask : look

	// Hold nibble: fallback active, held by switch, held by input
	task automatic holds(input string nm, input logic [15:0] exp);
		chk(nm, 16'({fallback_active_o, hold_switch_o, hold_input_o}),
			exp);
	endtask : holds

	// One-cycle remote request, answer seen at the taking edge
	task automatic remote(input logic [2:0] m, input logic go,
		input logic [15:0] exp);
		ext_run_i = go ? m : 3'h0;
		ext_stop_i = go ? 3'h0 : m;
		step(1);
		look("remote", exp);
		ext_run_i = 3'h0;
		ext_stop_i = 3'h0;
		step(1);
	endtask : remote

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out

	// Whole run needs well under a thousand cycles
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			close_out();
		end
	end

	initial begin
		step(4);
		rstn_i = 1'b1;
		step(2);
		chk("stop_out", output_channels_o, 16'h00fc);
		holds("hold_sw", 16'h6);
		for (int b = 0; b < N_EXT; b++) begin
			remote(3'(1 << b), 1'b1, 16'h1);
		end
		remote(3'h7, 1'b0, 16'h1);
		$display("switch stop test done");
		switch_run_i = 1'b1;
		step(3);
		look("sw_run", 16'hc);
		holds("hold_run", 16'h0);
		step(1);
		chk("run_out", output_channels_o, 16'h5a3c);
		for (int b = 0; b < N_EXT; b++) begin
			remote(3'(1 << b), 1'b0, 16'h2);
			remote(3'(1 << b), 1'b1, 16'hc);
		end
		remote(3'h1, 1'b0, 16'h2);
		chk("fb_out", output_channels_o, 16'h00fc);
		$display("remote test done");
		runstop_in_en_i = 1'b1;
		step(3);
		remote(3'h2, 1'b1, 16'h1);
		din_i[9] = 1'b1;
		step(3);
		look("in_rise", 16'hc);
		din_i[9] = 1'b0;
		step(3);
		look("in_low", 16'h2);
		holds("hold_in", 16'h5);
		runstop_in_en_i = 1'b0;
		step(1);
		$display("input test done");
		remote(3'h4, 1'b1, 16'hc);
		exception_i = 1'b1;
		step(1);
		chk("exc", 16'({exception_o, running_o}), 16'h2);
		step(1);
		chk("exc_out", output_channels_o, 16'h00fc);
		exception_i = 1'b0;
		step(2);
		remote(3'h1, 1'b1, 16'hc);
		$display("exception test done");
		lo_m = 16'h0020;
		step(4);
		chk("blank", 16'({cluster_blank_o, cluster_fault_o}), 16'h22);
		chk("cl_out", output_channels_o, 16'h5a0c);
		n = 0;
		while (cluster_blank_o[1] && n < 200) begin
			step(1);
			n++;
		end
		chk("rearm", 16'(n > RC - 5 && n < RC + 5), 16'h1);
		chk("probe", output_channels_o, 16'h5a3c);
		step(10);
		chk("reblank", 16'(cluster_blank_o), 16'h2);
		rearm_inhibit_i = 1'b1;
		step(RC + 20);
		chk("inhibit", 16'(cluster_blank_o), 16'h2);
		lo_m = '0;
		fault_clear_i = 1'b1;
		step(1);
		fault_clear_i = 1'b0;
		step(2);
		chk("clear", 16'({cluster_blank_o, cluster_fault_o}), 16'h0);
		rearm_inhibit_i = 1'b0;
		$display("protection test done");
		out_cmd_i = 16'hffff;
		for (int k = 0; k < 3; k++) begin
			// Drain synced shorts first; kind qualifies them unsynced
			hi_m = '0;
			lo_m = '0;
			step(3);
			out_kind_i = 2'(k);
			hi_m = (k == 1) ? 16'h0000 : 16'hfff0;
			lo_m = (k == 0) ? 16'h0000 : ((k == 1) ? 16'hfff0 : 16'hffff);
			step(8);
			chk("quiet", ch_fault_o | 16'(cluster_fault_o), 16'h0);
		end
		$display("kind test done");
		close_out();
	end
endmodule : test_rsofs_top
